//--- design/tewc_top.sv
// tewc_top: 16-bit up-counter with timer, event counter and window modes,
// a match register loaded in two byte writes, and an APB register slave.
// assumes: APB master on REF_CLK; COUNT_GATE_IN and LOW_FREQ_CLK are
// asynchronous pins; POWER_MODE comes from logic on REF_CLK.
`timescale 1ns/1ps

module tewc_top
   import tewc_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // count / gate pin and low clock pin
   input wire logic COUNT_GATE_IN,
   input wire logic LOW_FREQ_CLK,
   // system power mode
   input wire tewc_pkg::tewc_pmode_t POWER_MODE,
   // interrupt
   output logic IRQ
);
   import tewc_pkg::*;

   typedef struct packed {
      logic run;
      logic [1:0] mode;
      logic [2:0] src;
      logic tap;
      logic [15:0] match;
      logic [7:0] low_stage;
      logic low_pend;
      logic [15:0] count;
      logic gate_s1;
      logic gate_s2;
      logic gate_prev;
      tewc_pmode_t pm_prev;
      logic [0:0] sts;
      logic [0:0] ena;
      logic irq;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
   } tewc_core_t;

   tewc_core_t q, d;
   tewc_tick_if tk ();

   // prescaler for the internal count clocks
   tewc_prescaler u_pre (
      .REF_CLK(REF_CLK),
      .RST(RST),
      .LOW_FREQ_CLK(LOW_FREQ_CLK),
      .tk(tk.pre)
   );

   // slow and sleep modes move the two slow taps to the low clock and stop the mid, fast and low taps
   assign tk.src_sel = q.src;
   assign tk.tap_sel = q.tap;
   assign tk.slow = (POWER_MODE == TEWC_PM_LOW_SPEED_MODE_ONE) || (POWER_MODE == TEWC_PM_LOW_SPEED_MODE_TWO) ||
                    (POWER_MODE == TEWC_PM_SLEEP);

   // compare of a count value against the match value in use
   function automatic logic hit(input logic [15:0] v, input logic [15:0] m, input logic warm);
      if (warm) begin
         return v[15:TEWC_WARM_LOW_BITS] == m[15:TEWC_WARM_LOW_BITS];
      end
      return v == m;
   endfunction : hit

   // register read mux
   function automatic logic [31:0] rd_word(input tewc_core_t s, input logic [7:0] a);
      logic [31:0] r;
      r = 32'h00000000;
      case (a)
         TEWC_OFS_CTRL: begin
            r[TEWC_CTRL_RUN_POS] = s.run;
            r[TEWC_CTRL_MODE_POS +: 2] = s.mode;
            r[TEWC_CTRL_SRC_POS +: 3] = s.src;
            r[TEWC_CTRL_TAP_POS] = s.tap;
         end
         TEWC_OFS_MATCH_LOW: r[7:0] = s.low_stage;
         TEWC_OFS_MATCH: r[15:0] = s.match;
         TEWC_OFS_COUNT: r[15:0] = s.count;
         TEWC_OFS_IRQ_STATUS: r[TEWC_IRQ_MATCH_POS] = s.sts[0];
         TEWC_OFS_IRQ_ENABLE: r[TEWC_IRQ_MATCH_POS] = s.ena[0];
         default: r = 32'h00000000;
      endcase
      return r;
   endfunction : rd_word

   // whole next state: bus, match load, counter, interrupt
   always_comb begin
      logic acc;
      logic wr;
      logic mapped;
      logic warm;
      logic slow;
      logic rise;
      logic fall;
      logic ev;
      logic [15:0] nxt;
      logic [0:0] clr;
      acc = 1'b0;
      wr = 1'b0;
      mapped = 1'b0;
      warm = 1'b0;
      slow = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      ev = 1'b0;
      nxt = 16'h0000;
      clr = 1'b0;
      d = q;

      // pin synchroniser, only the second stage is looked at
      d.gate_s1 = COUNT_GATE_IN;
      d.gate_s2 = q.gate_s1;
      d.gate_prev = q.gate_s2;
      rise = q.gate_s2 & ~q.gate_prev;
      fall = ~q.gate_s2 & q.gate_prev;
      d.pm_prev = POWER_MODE;
      slow = tk.slow;
      // warm-up compare in low speed two
      warm = (POWER_MODE == TEWC_PM_LOW_SPEED_MODE_TWO) && (q.src == TEWC_SRC_HF);

      // apb: one wait state, the access completes on the second access edge
      case (PADDR)
         TEWC_OFS_CTRL, TEWC_OFS_MATCH_LOW, TEWC_OFS_MATCH_HIGH, TEWC_OFS_MATCH,
         TEWC_OFS_COUNT, TEWC_OFS_IRQ_STATUS, TEWC_OFS_IRQ_CLEAR,
         TEWC_OFS_IRQ_ENABLE: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
      acc = PSEL & PENABLE;
      d.pready = acc & ~q.pready;
      if (acc && !q.pready) begin
         d.prdata = PWRITE ? 32'h00000000 : rd_word(q, PADDR);
         d.pslverr = ~mapped;
      end
      wr = acc & q.pready & PWRITE & mapped;

      // register writes
      if (wr) begin
         case (PADDR)
            TEWC_OFS_CTRL: begin
               d.run = PWDATA[TEWC_CTRL_RUN_POS];
               d.mode = PWDATA[TEWC_CTRL_MODE_POS +: 2];
               d.src = PWDATA[TEWC_CTRL_SRC_POS +: 3];
               d.tap = PWDATA[TEWC_CTRL_TAP_POS];
            end
            TEWC_OFS_MATCH_LOW: begin
               d.low_stage = PWDATA[7:0];
               d.low_pend = 1'b1;
            end
            TEWC_OFS_MATCH_HIGH: begin
               // warm-up use needs no low byte, its bits are not compared
               if (q.low_pend || warm) begin
                  d.match = {PWDATA[7:0], q.low_stage};
               end
               d.low_pend = 1'b0;
            end
            TEWC_OFS_IRQ_CLEAR: clr = PWDATA[TEWC_IRQ_MATCH_POS];
            TEWC_OFS_IRQ_ENABLE: d.ena = PWDATA[TEWC_IRQ_MATCH_POS];
            default: d.ena = q.ena;
         endcase
      end

      if ((POWER_MODE == TEWC_PM_STOP) && (q.pm_prev != TEWC_PM_STOP)) begin
         d.run = 1'b0;
      end

      // counting; compare always uses q.match, the committed value
      nxt = q.count + 16'h0001;
      case (q.mode)
         TEWC_MODE_TIMER: begin
            if (tk.tick) begin
               ev = hit(nxt, q.match, warm);
               d.count = ev ? TEWC_COUNT_RST : nxt;
            end
         end
         TEWC_MODE_EVENT: begin
            if (rise) begin
               d.count = nxt;
            end
            if (fall && hit(q.count, q.match, 1'b0)) begin
               ev = 1'b1;
               d.count = TEWC_COUNT_RST;
            end
         end
         // window: tick counts while pin high
         TEWC_MODE_WINDOW: begin
            // not usable in slow modes, the count holds while slow is set
            if (tk.tick && q.gate_s2 && !slow) begin
               ev = hit(nxt, q.match, 1'b0);
               d.count = ev ? TEWC_COUNT_RST : nxt;
            end
         end
         default: d.count = TEWC_COUNT_RST;
      endcase

      if (!q.run) begin
         ev = 1'b0;
         d.count = TEWC_COUNT_RST;
      end

      // sticky status: a new match wins over a clear in the same cycle
      d.sts = (q.sts & ~clr) | ev;
      d.irq = |(q.sts & q.ena);
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         q <= '{run: 1'b0, mode: TEWC_MODE_RST, src: TEWC_SRC_RST, tap: 1'b0,
                match: TEWC_MATCH_RST, low_stage: 8'h00, low_pend: 1'b0,
                count: TEWC_COUNT_RST, gate_s1: 1'b0, gate_s2: 1'b0, gate_prev: 1'b0,
                pm_prev: TEWC_PM_NORMAL1, sts: 1'b0, ena: 1'b0, irq: 1'b0,
                pready: 1'b0, prdata: 32'h00000000, pslverr: 1'b0};
      end else begin
         q <= d;
      end
   end

   // outputs straight from the state flops
   assign PRDATA = q.prdata;
   assign PREADY = q.pready;
   assign PSLVERR = q.pslverr;
   assign IRQ = q.irq;

endmodule : tewc_top

//--- pkg/tewc_pkg.sv
// tewc_pkg: register map, field positions, reset values and prescaler taps
// for the 16-bit timer / event / window counter.
// assumes: 32-bit APB data, one aligned word per register.
package tewc_pkg;

   // register byte offsets
   localparam logic [7:0] TEWC_OFS_CTRL = 8'h00;
   localparam logic [7:0] TEWC_OFS_MATCH_LOW = 8'h04;
   localparam logic [7:0] TEWC_OFS_MATCH_HIGH = 8'h08;
   localparam logic [7:0] TEWC_OFS_MATCH = 8'h0C;
   localparam logic [7:0] TEWC_OFS_COUNT = 8'h10;
   localparam logic [7:0] TEWC_OFS_IRQ_STATUS = 8'h14;
   localparam logic [7:0] TEWC_OFS_IRQ_CLEAR = 8'h18;
   localparam logic [7:0] TEWC_OFS_IRQ_ENABLE = 8'h1C;

   // control register field positions
   localparam int TEWC_CTRL_RUN_POS = 0;
   localparam int TEWC_CTRL_MODE_POS = 1;
   localparam int TEWC_CTRL_SRC_POS = 3;
   localparam int TEWC_CTRL_TAP_POS = 6;

   // status / enable bit positions
   localparam int TEWC_IRQ_MATCH_POS = 0;

   // reset values
   localparam logic [15:0] TEWC_MATCH_RST = 16'hFFFF;
   localparam logic [15:0] TEWC_COUNT_RST = 16'h0000;
   localparam logic [1:0] TEWC_MODE_RST = 2'h0;
   localparam logic [2:0] TEWC_SRC_RST = 3'h0;

   // operating modes, as held in the mode field
   localparam logic [1:0] TEWC_MODE_TIMER = 2'h0;
   localparam logic [1:0] TEWC_MODE_EVENT = 2'h1;
   localparam logic [1:0] TEWC_MODE_WINDOW = 2'h2;

   // source clock select codes
   localparam logic [2:0] TEWC_SRC_SLOWEST = 3'h0;
   localparam logic [2:0] TEWC_SRC_SLOW = 3'h1;
   localparam logic [2:0] TEWC_SRC_MID = 3'h2;
   localparam logic [2:0] TEWC_SRC_FAST = 3'h3;
   localparam logic [2:0] TEWC_SRC_HF = 3'h4;
   localparam logic [2:0] TEWC_SRC_LF = 3'h5;

   // prescaler taps, as powers of two of the base clock
   localparam int TEWC_HF_DIV_W = 23;
   localparam int TEWC_LF_DIV_W = 15;
   localparam int TEWC_HF_TAP_SLOWEST = 23;
   localparam int TEWC_HF_TAP_SLOW = 13;
   localparam int TEWC_HF_TAP_MID = 8;
   localparam int TEWC_HF_TAP_FAST = 3;
   localparam int TEWC_LF_TAP_SLOWEST = 15;
   localparam int TEWC_LF_TAP_SLOW = 5;

   // bits ignored by the compare in warm-up use
   localparam int TEWC_WARM_LOW_BITS = 11;

   // power modes of the surrounding system
   typedef enum logic [2:0] {
      TEWC_PM_NORMAL1,
      TEWC_PM_NORMAL_MODE_TWO,
      TEWC_PM_IDLE,
      TEWC_PM_LOW_SPEED_MODE_ONE,
      TEWC_PM_LOW_SPEED_MODE_TWO,
      TEWC_PM_SLEEP,
      TEWC_PM_STOP
   } tewc_pmode_t;

endpackage : tewc_pkg

//--- pkg/tewc_tick_if.sv
// tewc_tick_if: source clock selection going to the prescaler and the
// selected count tick coming back.
// assumes: both ends on REF_CLK.
`timescale 1ns/1ps
interface tewc_tick_if;
   logic [2:0] src_sel;
   logic tap_sel;
   logic slow;
   logic tick;
   modport core (output src_sel, output tap_sel, output slow, input tick);
   modport pre (input src_sel, input tap_sel, input slow, output tick);
endinterface : tewc_tick_if

//--- design/tewc_prescaler.sv
// tewc_prescaler: divides the high-frequency clock and the synchronised
// low-frequency clock and returns a one-cycle tick for the selected source.
// assumes: REF_CLK is the high-frequency clock; the low clock arrives
// as a slow pin, far below REF_CLK.
`timescale 1ns/1ps
module tewc_prescaler
   import tewc_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // low-frequency clock pin
   input wire logic LOW_FREQ_CLK,
   // selection and tick
   tewc_tick_if.pre tk
);

   typedef struct packed {
      logic lf_s1;
      logic lf_s2;
      logic lf_prev;
      logic [TEWC_HF_DIV_W-1:0] hf_div;
      logic [TEWC_LF_DIV_W-1:0] lf_div;
      logic tick;
   } tewc_pre_t;

   tewc_pre_t q, d;

   // true when the low k bits of a divider are all ones
   function automatic logic hf_wrap(input logic [TEWC_HF_DIV_W-1:0] v, input int k);
      logic [TEWC_HF_DIV_W:0] mask;
      mask = (24'h000001 << k) - 24'h000001;
      return ({1'b0, v} & mask) == mask;
   endfunction : hf_wrap

   function automatic logic lf_wrap(input logic [TEWC_LF_DIV_W-1:0] v, input int k);
      logic [TEWC_LF_DIV_W:0] mask;
      mask = (16'h0001 << k) - 16'h0001;
      return ({1'b0, v} & mask) == mask;
   endfunction : lf_wrap

   // dividers and tap selection
   always_comb begin
      logic lf_edge;
      logic use_lf;
      lf_edge = 1'b0;
      use_lf = 1'b0;
      d = q;
      d.lf_s1 = LOW_FREQ_CLK;
      d.lf_s2 = q.lf_s1;
      d.lf_prev = q.lf_s2;
      lf_edge = q.lf_s2 & ~q.lf_prev;
      d.hf_div = q.hf_div + 1'b1;
      if (lf_edge) begin
         d.lf_div = q.lf_div + 1'b1;
      end
      // slow modes and the tap select move the two slow taps to the low clock
      use_lf = tk.slow | tk.tap_sel;
      case (tk.src_sel)
         TEWC_SRC_SLOWEST: begin
            d.tick = use_lf ? (lf_edge & lf_wrap(q.lf_div, TEWC_LF_TAP_SLOWEST))
                            : hf_wrap(q.hf_div, TEWC_HF_TAP_SLOWEST);
         end
         TEWC_SRC_SLOW: begin
            d.tick = use_lf ? (lf_edge & lf_wrap(q.lf_div, TEWC_LF_TAP_SLOW))
                            : hf_wrap(q.hf_div, TEWC_HF_TAP_SLOW);
         end
         TEWC_SRC_MID: d.tick = ~tk.slow & hf_wrap(q.hf_div, TEWC_HF_TAP_MID);
         TEWC_SRC_FAST: d.tick = ~tk.slow & hf_wrap(q.hf_div, TEWC_HF_TAP_FAST);
         TEWC_SRC_HF: d.tick = 1'b1;
         TEWC_SRC_LF: d.tick = ~tk.slow & lf_edge;
         default: d.tick = 1'b0;
      endcase
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tk.tick = q.tick;

endmodule : tewc_prescaler

//--- tb/tewc_monitor.sv
// tewc_monitor: port-level checks on the apb slave and interrupt.
// assumes: bound into tewc_top; single clock REF_CLK.
`timescale 1ns/1ps
module tewc_monitor
   import tewc_pkg::*;
(
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   // apb
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   // system side
   input wire tewc_pkg::tewc_pmode_t POWER_MODE,
   input wire logic IRQ
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   logic [6:0] ctrl_q;
   logic [15:0] match_q;
   logic [7:0] low_q;
   logic pend_q;
   logic ena_q;
   tewc_pmode_t pm_q;
   logic wr;
   logic rd;
   assign wr = PSEL && PENABLE && PREADY && PWRITE;
   assign rd = PSEL && PENABLE && PREADY && !PWRITE;
   // shadow of software state; stop entry is last so it beats a write
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ctrl_q <= 7'h00;
         match_q <= TEWC_MATCH_RST;
         low_q <= 8'h00;
         pend_q <= 1'b0;
         ena_q <= 1'b0;
         pm_q <= TEWC_PM_NORMAL1;
      end else begin
         pm_q <= POWER_MODE;
         if (wr && PADDR == TEWC_OFS_CTRL) ctrl_q <= PWDATA[6:0];
         if (wr && PADDR == TEWC_OFS_IRQ_ENABLE) ena_q <= PWDATA[0];
         if (wr && PADDR == TEWC_OFS_MATCH_LOW) begin
            low_q <= PWDATA[7:0];
            pend_q <= 1'b1;
         end
         if (wr && PADDR == TEWC_OFS_MATCH_HIGH) begin
            pend_q <= 1'b0;
            if (pend_q || (POWER_MODE == TEWC_PM_LOW_SPEED_MODE_TWO && ctrl_q[5:3] == TEWC_SRC_HF))
               match_q <= {PWDATA[7:0], low_q};
         end
         if (POWER_MODE == TEWC_PM_STOP && pm_q != TEWC_PM_STOP) ctrl_q[0] <= 1'b0;
      end
   end
   sequence s_wait;
      PSEL && PENABLE && !PREADY;
   endsequence
   sequence s_pulse;
      PREADY ##1 !PREADY;
   endsequence
   a_ready_wait: assert property (s_wait |=> s_pulse)
      else $error("ready not one cycle after access");
   a_ready_single: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   a_err_unmapped: assert property (PREADY && (PADDR[1:0] != 2'h0 || PADDR > 8'h1C) |-> PSLVERR)
      else $error("unmapped access not refused");
   a_err_zero: assert property (PREADY && PSLVERR && !PWRITE |-> PRDATA == 32'h0)
      else $error("refused read returns data");
   a_ctrl_mirror: assert property (rd && PADDR == TEWC_OFS_CTRL |->
      PRDATA[6:0] == ctrl_q) else $error("control read differs");
   a_idle_count: assert property (rd && PADDR == TEWC_OFS_COUNT && !ctrl_q[0] |->
      PRDATA[15:0] == 16'h0) else $error("count not zero while halted");
   a_match_load: assert property (rd && PADDR == TEWC_OFS_MATCH |->
      PRDATA[15:0] == match_q) else $error("match in use differs");
   a_irq_enable: assert property (IRQ |-> $past(ena_q))
      else $error("interrupt while disabled");
endmodule : tewc_monitor
bind tewc_top tewc_monitor u_mon (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .POWER_MODE(POWER_MODE), .IRQ(IRQ));

//--- tb/tewc_pin_model.sv
// tewc_pin_model: outside source of the count / gate pin.
// assumes: tasks called from the bench; levels change after an edge.
`timescale 1ns/1ps
module tewc_pin_model (
   // clock
   input wire logic ref_clk,
   // pin
   output logic pin
);
   initial pin = 1'b0;
   // set a level, then hold it n edges
   task automatic drive(input logic v, input int n);
      @(posedge ref_clk);
      pin <= v;
      repeat (n) @(posedge ref_clk);
   endtask : drive
   task automatic pulse(input int n, input int w);
      repeat (n) begin
         drive(1'b1, w);
         drive(1'b0, w);
      end
   endtask : pulse
endmodule : tewc_pin_model

//--- tb/timer_event_window_counter_tb.sv
// timer_event_window_counter_tb: directed tests of tewc_top over apb.
// assumes: tewc_pin_model drives the count pin; low clock held low.
`timescale 1ns/1ps
module timer_event_window_counter_tb;
   import tewc_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic irq;
   logic gate;
   tewc_pmode_t pmode = TEWC_PM_NORMAL_MODE_TWO;
   int errors = 0;
   int checks = 0;
   tewc_top DUT (.REF_CLK(ref_clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .COUNT_GATE_IN(gate), .LOW_FREQ_CLK(1'b0), .POWER_MODE(pmode),
      .IRQ(irq));
   tewc_pin_model u_pin (.ref_clk(ref_clk), .pin(gate));
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_of_test
   task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   // one apb transfer; request held until pready is sampled
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) errors++;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rc(input string n, input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(n, r, x);
   endtask : rc
   // halted, status cleared, then the new control word
   task automatic start(input logic [31:0] c);
      wr(TEWC_OFS_CTRL, 32'h0);
      wr(TEWC_OFS_IRQ_CLEAR, 32'h1);
      wr(TEWC_OFS_CTRL, c);
   endtask : start
   task automatic wait_irq();
      int n = 0;
      while (irq !== 1'b1 && n < 9000) begin
         @(posedge ref_clk);
         n++;
      end
      // a wait that runs out is a failure, not a silent return
      if (n >= 9000) errors++;
   endtask : wait_irq
   // cycles between two successive matches
   task automatic period(input string n, input int x);
      time t0;
      wait_irq();
      t0 = $time;
      wr(TEWC_OFS_IRQ_CLEAR, 32'h1);
      repeat (2) @(posedge ref_clk);
      wait_irq();
      chk(n, 32'(($time - t0) / 20), 32'(x));
   endtask : period
   task automatic t_reset();
      logic [31:0] r;
      logic e;
      rc("ctrl", TEWC_OFS_CTRL, 32'h0);
      rc("match", TEWC_OFS_MATCH, 32'hFFFF);
      rc("count", TEWC_OFS_COUNT, 32'h0);
      rc("status", TEWC_OFS_IRQ_STATUS, 32'h0);
      rc("enable", TEWC_OFS_IRQ_ENABLE, 32'h0);
      apb(1'b0, 8'h20, 32'h0, r, e);
      chk("unmapped", {r[30:0], e}, 32'h1);
   endtask : t_reset
   task automatic t_load();
      wr(TEWC_OFS_MATCH_LOW, 32'h40);
      rc("low only", TEWC_OFS_MATCH, 32'hFFFF);
      rc("staged", TEWC_OFS_MATCH_LOW, 32'h40);
      wr(TEWC_OFS_MATCH_HIGH, 32'h0);
      rc("pair", TEWC_OFS_MATCH, 32'h40);
      wr(TEWC_OFS_MATCH_HIGH, 32'h12);
      rc("lone high", TEWC_OFS_MATCH, 32'h40);
   endtask : t_load
   task automatic t_timer();
      wr(TEWC_OFS_IRQ_ENABLE, 32'h1);
      start(32'h21);
      period("timer period", 64);
      // divided source: one tick every eight cycles
      start(32'h19);
      period("fast period", 512);
      wr(TEWC_OFS_IRQ_ENABLE, 32'h0);
      repeat (2) @(posedge ref_clk);
      chk("masked", 32'(irq), 32'h0);
      rc("sticky", TEWC_OFS_IRQ_STATUS, 32'h1);
      wr(TEWC_OFS_CTRL, 32'h0);
      wr(TEWC_OFS_IRQ_CLEAR, 32'h1);
      wr(TEWC_OFS_IRQ_ENABLE, 32'h1);
      repeat (100) @(posedge ref_clk);
      chk("halted irq", 32'(irq), 32'h0);
      rc("halted count", TEWC_OFS_COUNT, 32'h0);
   endtask : t_timer
   task automatic t_event();
      wr(TEWC_OFS_MATCH_LOW, 32'h03);
      wr(TEWC_OFS_MATCH_HIGH, 32'h00);
      start(32'h03);
      u_pin.pulse(2, 8);
      u_pin.drive(1'b1, 12);
      rc("event count", TEWC_OFS_COUNT, 32'h3);
      chk("no early irq", 32'(irq), 32'h0);
      u_pin.drive(1'b0, 12);
      chk("irq on fall", 32'(irq), 32'h1);
      rc("event cleared", TEWC_OFS_COUNT, 32'h0);
   endtask : t_event
   task automatic t_window();
      logic [31:0] r;
      logic e;
      wr(TEWC_OFS_MATCH_LOW, 32'h00);
      wr(TEWC_OFS_MATCH_HIGH, 32'h01);
      start(32'h25);
      u_pin.drive(1'b0, 20);
      rc("gate low", TEWC_OFS_COUNT, 32'h0);
      u_pin.drive(1'b1, 40);
      u_pin.drive(1'b0, 10);
      apb(1'b0, TEWC_OFS_COUNT, 32'h0, r, e);
      chk("gate span", 32'(r >= 38 && r <= 44), 32'h1);
      repeat (20) @(posedge ref_clk);
      rc("gate closed", TEWC_OFS_COUNT, r);
   endtask : t_window
   task automatic t_stop();
      start(32'h21);
      @(posedge ref_clk);
      pmode <= TEWC_PM_STOP;
      repeat (4) @(posedge ref_clk);
      rc("stop ctrl", TEWC_OFS_CTRL, 32'h20);
      rc("stop count", TEWC_OFS_COUNT, 32'h0);
      pmode <= TEWC_PM_NORMAL_MODE_TWO;
   endtask : t_stop
   task automatic t_warm();
      wr(TEWC_OFS_CTRL, 32'h20);
      pmode <= TEWC_PM_LOW_SPEED_MODE_TWO;
      wr(TEWC_OFS_MATCH_HIGH, 32'h10);
      rc("warm load", TEWC_OFS_MATCH, 32'h1000);
      start(32'h21);
      period("warm period", 4096);
      wr(TEWC_OFS_CTRL, 32'h0);
      pmode <= TEWC_PM_NORMAL_MODE_TWO;
   endtask : t_warm
   // main sequence; low clock tied, every other input exercised
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_load();
      t_timer();
      t_event();
      t_window();
      t_stop();
      t_warm();
      end_of_test();
   end
   // watchdog sized well above the warm-up span
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      end_of_test();
   end
endmodule : timer_event_window_counter_tb
